// >>> design/bscd_map.vh
// Constants for the burst SRAM cycle decode block
`ifndef BSCD_MAP_VH
`define BSCD_MAP_VH

`define BSCD_DATA_W     32
`define BSCD_ADDR_W     17
`define BSCD_LANES      4
`define BSCD_LANE_W     8
`define BSCD_DEPTH      131072
`define BSCD_SLEEP_CYC  2

// Cycle type codes
`define BSCD_CYC_W      4
`define BSCD_CYC_DESEL  4'h0
`define BSCD_CYC_BRD    4'h1
`define BSCD_CYC_CRD    4'h2
`define BSCD_CYC_SRD    4'h3
`define BSCD_CYC_BWR    4'h4
`define BSCD_CYC_CWR    4'h5
`define BSCD_CYC_SWR    4'h6
`define BSCD_CYC_SLEEP  4'h7
`define BSCD_CYC_IDLE   4'h8

// Address source codes
`define BSCD_SRC_NONE   2'h0
`define BSCD_SRC_EXT    2'h1
`define BSCD_SRC_CUR    2'h2
`define BSCD_SRC_NEXT   2'h3

`endif

// >>> design/bscd_core.v
// Cycle decode, burst counter, byte writes and bus drive of a pipelined burst SRAM
// How it works
// - Deselect on chip_sel_a_n high with controller strobe, or bad selects with a strobe.
// - Selected processor strobe, or controller strobe without write, begins read at external address.
// - Processor strobe cycle is always a read; write qualifiers ignored then.
// - No strobe in a read with advance low steps burst address, reads on.
// - No strobe in a read with advance high holds address, repeats read.
// - After a strobe, no strobe, advance high, write active writes at current address.
// - Selected controller strobe with write active writes external address same cycle.
// - No strobe in write burst with advance low steps address and writes.
// - No strobe in write burst with advance high holds address and writes.
// - Writes only on a controller strobe or in a later no-strobe cycle of a burst begun by either strobe.
// - Output enable masked while a write is in progress.
// - Output enable acts combinationally on drivers, never clocked.
// - Read drives data only with output enable low and device selected.
// - Global write writes all bytes; both write enables high means read.
// - Byte write enable low writes each lane whose select is low.
// - Two-bit wrapping burst counter, linear or interleaved by order pin.
// - Controller strobe write completes in one cycle, advance ignored.
// - Sleep entry and exit take two cycles; host idles beforehand.
`include "bscd_map.vh"
`default_nettype none

module bscd_core (
  input  wire                       clk,
  input  wire                       sys_rst,
  input  wire [`BSCD_ADDR_W-1:0]    addr,
  input  wire                       processor_addr_strobe_n,
  input  wire                       controller_addr_strobe_n,
  input  wire                       burst_advance_n,
  input  wire                       chip_sel_a_n,
  input  wire                       chip_sel_b,
  input  wire                       chip_sel_c_n,
  input  wire                       global_write_n,
  input  wire                       byte_write_en_n,
  input  wire [`BSCD_LANES-1:0]     byte_lane_sel_n,
  input  wire                       output_enable_n,
  input  wire                       sleep_request,
  input  wire                       burst_order_linear,
  input  wire [`BSCD_DATA_W-1:0]    write_data,
  output wire [`BSCD_DATA_W-1:0]    read_data,
  output wire                       data_bus_oe,
  output wire [`BSCD_CYC_W-1:0]     cycle_type,
  output wire [1:0]                 addr_source,
  output wire                       sleeping
);

  // ********************************
  // Storage and state
  // ********************************
  reg  [`BSCD_ADDR_W-1:0]  base_q;
  reg  [1:0]               start_q;
  reg  [1:0]               step_q;
  reg                      active_q;
  reg                      in_write_q;
  reg                      wr_ok_q;
  reg  [`BSCD_DATA_W-1:0]  rd_q;
  reg                      rd_vld_q;
  reg  [`BSCD_CYC_W-1:0]   cyc_q;
  reg  [1:0]               src_q;
  reg  [1:0]               slp_state_q;

  // Sleep entry and exit states
  localparam [1:0] SLP_AWAKE  = 2'h0;
  localparam [1:0] SLP_ENTER  = 2'h1;
  localparam [1:0] SLP_ASLEEP = 2'h2;
  localparam [1:0] SLP_EXIT   = 2'h3;

  // ********************************
  // Decode
  // ********************************
  wire sel_ok   = ~chip_sel_a_n & chip_sel_b & ~chip_sel_c_n;
  wire psp      = ~processor_addr_strobe_n & ~chip_sel_a_n;
  wire csc      = ~controller_addr_strobe_n;
  wire strobe   = psp | csc;
  wire [`BSCD_LANES-1:0] lanes_we;
  wire wr_req   = |lanes_we;
  wire [1:0] step_nx = step_q + 2'h1;
  // Still asleep during the two exit edges
  wire       sleep_on = (slp_state_q == SLP_ASLEEP) | (slp_state_q == SLP_EXIT);
  reg  [1:0] cur_lo;
  reg  [1:0] nxt_lo;

  // Linear adds the step, interleaved flips the start bits
  always @* begin
    if (burst_order_linear) begin
      cur_lo = start_q + step_q;
      nxt_lo = start_q + step_nx;
    end else begin
      cur_lo = start_q ^ step_q;
      nxt_lo = start_q ^ step_nx;
    end
  end

  // Per lane write qualification
  genvar g;
  generate
    for (g = 0; g < `BSCD_LANES; g = g + 1) begin : g_lane
      assign lanes_we[g] = ~global_write_n | (~byte_write_en_n & ~byte_lane_sel_n[g]);
    end
  endgenerate

  // Cycle decode in priority order
  reg [`BSCD_CYC_W-1:0]  cyc_d;
  reg [1:0]              src_d;
  always @* begin
    cyc_d = `BSCD_CYC_IDLE;
    src_d = `BSCD_SRC_NONE;
    if (sleep_on || sleep_request) begin
      cyc_d = `BSCD_CYC_SLEEP;
    end else if (strobe && !sel_ok) begin
      cyc_d = `BSCD_CYC_DESEL;
    end else if (psp) begin
      // Write inputs wait for the next edge
      cyc_d = `BSCD_CYC_BRD;
      src_d = `BSCD_SRC_EXT;
    end else if (csc) begin
      src_d = `BSCD_SRC_EXT;
      cyc_d = wr_req ? `BSCD_CYC_BWR : `BSCD_CYC_BRD;
    end else if (active_q) begin
      if (wr_req && wr_ok_q) begin
        cyc_d = burst_advance_n ? (in_write_q ? `BSCD_CYC_SWR : `BSCD_CYC_BWR)
                                : `BSCD_CYC_CWR;
      end else begin
        cyc_d = burst_advance_n ? `BSCD_CYC_SRD : `BSCD_CYC_CRD;
      end
      src_d = burst_advance_n ? `BSCD_SRC_CUR : `BSCD_SRC_NEXT;
    end
  end

  reg is_wr;
  reg is_rd;
  always @* begin
    is_wr = 1'b0;
    is_rd = 1'b0;
    case (cyc_d)
      `BSCD_CYC_BRD, `BSCD_CYC_CRD, `BSCD_CYC_SRD: begin
        is_rd = 1'b1;
      end
      `BSCD_CYC_BWR, `BSCD_CYC_CWR, `BSCD_CYC_SWR: begin
        is_wr = 1'b1;
      end
      default: begin
        is_rd = 1'b0;
      end
    endcase
  end

  // ********************************
  // Address select
  // ********************************
  wire [`BSCD_ADDR_W-1:0] ext_a = addr;
  wire [`BSCD_ADDR_W-1:0] cur_a = {base_q[`BSCD_ADDR_W-1:2], cur_lo};
  wire [`BSCD_ADDR_W-1:0] nxt_a = {base_q[`BSCD_ADDR_W-1:2], nxt_lo};
  reg  [`BSCD_ADDR_W-1:0] use_a;
  always @* begin
    case (src_d)
      `BSCD_SRC_EXT: begin
        use_a = ext_a;
      end
      `BSCD_SRC_NEXT: begin
        use_a = nxt_a;
      end
      default: begin
        use_a = cur_a;
      end
    endcase
  end

  // ********************************
  // Burst counter and cycle state
  // ********************************
  always @(posedge clk) begin
    if (sys_rst) begin
      base_q     <= {`BSCD_ADDR_W{1'b0}};
      start_q    <= 2'h0;
      step_q     <= 2'h0;
      cyc_q      <= `BSCD_CYC_IDLE;
      src_q      <= `BSCD_SRC_NONE;
    end else begin
      cyc_q <= cyc_d;
      src_q <= src_d;
      if (src_d == `BSCD_SRC_EXT) begin
        base_q  <= addr;
        start_q <= addr[1:0];
        step_q  <= 2'h0;
      end else if (src_d == `BSCD_SRC_NEXT) begin
        step_q  <= step_nx;
      end
    end
  end

  // Burst flags: a deselect or sleep ends the burst
  always @(posedge clk) begin
    if (sys_rst) begin
      active_q   <= 1'b0;
      in_write_q <= 1'b0;
      wr_ok_q    <= 1'b0;
    end else if (cyc_d == `BSCD_CYC_DESEL || cyc_d == `BSCD_CYC_SLEEP) begin
      active_q   <= 1'b0;
      in_write_q <= 1'b0;
      wr_ok_q    <= 1'b0;
    end else if (is_rd || is_wr) begin
      active_q   <= 1'b1;
      in_write_q <= is_wr;
      wr_ok_q    <= 1'b1;
    end
  end

  // ********************************
  // Array access and output register
  // ********************************
  wire [`BSCD_DATA_W-1:0] rd_word;

  // One byte wide array per lane, so each has a single writer
  generate
    for (g = 0; g < `BSCD_LANES; g = g + 1) begin : g_wr
      reg [`BSCD_LANE_W-1:0] lane_mem [0:`BSCD_DEPTH-1];
      always @(posedge clk) begin
        if (!sys_rst && is_wr && lanes_we[g]) begin
          lane_mem[use_a] <= write_data[g*`BSCD_LANE_W +: `BSCD_LANE_W];
        end
      end
      assign rd_word[g*`BSCD_LANE_W +: `BSCD_LANE_W] = lane_mem[use_a];
    end
  endgenerate

  always @(posedge clk) begin
    if (sys_rst) begin
      rd_q     <= {`BSCD_DATA_W{1'b0}};
      rd_vld_q <= 1'b0;
    end else begin
      rd_vld_q <= is_rd;
      if (is_rd) begin
        rd_q <= rd_word;
      end
    end
  end

  // ********************************
  // Sleep entry and exit
  // ********************************
  // Two edges of a steady request move the state either way
  reg [1:0] slp_state_d;
  always @* begin
    slp_state_d = slp_state_q;
    case (slp_state_q)
      SLP_AWAKE: begin
        if (sleep_request) begin
          slp_state_d = SLP_ENTER;
        end
      end
      SLP_ENTER: begin
        if (sleep_request) begin
          slp_state_d = SLP_ASLEEP;
        end else begin
          slp_state_d = SLP_AWAKE;
        end
      end
      SLP_ASLEEP: begin
        if (!sleep_request) begin
          slp_state_d = SLP_EXIT;
        end
      end
      SLP_EXIT: begin
        if (sleep_request) begin
          slp_state_d = SLP_ASLEEP;
        end else begin
          slp_state_d = SLP_AWAKE;
        end
      end
      default: begin
        slp_state_d = SLP_AWAKE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      slp_state_q <= SLP_AWAKE;
    end else begin
      slp_state_q <= slp_state_d;
    end
  end

  // ********************************
  // Bus drive
  // ********************************
  wire rd_cycle_q = (cyc_q == `BSCD_CYC_BRD) | (cyc_q == `BSCD_CYC_CRD) |
                    (cyc_q == `BSCD_CYC_SRD);
  wire wr_cycle_q = (cyc_q == `BSCD_CYC_BWR) | (cyc_q == `BSCD_CYC_CWR) |
                    (cyc_q == `BSCD_CYC_SWR);

  // Enable follows the live pin; write cycles mask it whatever the host does
  assign data_bus_oe = rd_vld_q & ~output_enable_n & ~sleep_request &
                       (rd_cycle_q | (cyc_q == `BSCD_CYC_IDLE)) &
                       ~wr_cycle_q & ~is_wr;
  assign read_data   = rd_q;
  assign cycle_type  = cyc_q;
  assign addr_source = src_q;
  assign sleeping    = sleep_on;

endmodule
`default_nettype wire

// >>> verification/bscd_checker.sv
// Concurrent checks on the cycle decode ports
`default_nettype none
module bscd_checker (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       processor_addr_strobe_n,
  input wire logic       controller_addr_strobe_n,
  input wire logic       burst_advance_n,
  input wire logic       chip_sel_a_n,
  input wire logic       chip_sel_b,
  input wire logic       chip_sel_c_n,
  input wire logic       global_write_n,
  input wire logic       byte_write_en_n,
  input wire logic       output_enable_n,
  input wire logic       sleep_request,
  input wire logic       sleeping,
  input wire logic       data_bus_oe,
  input wire logic [3:0] cycle_type,
  input wire logic [1:0] addr_source
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wire logic [5:0] res = {cycle_type, addr_source};
  wire logic awk = !sleep_request && !sleeping;
  wire logic sel = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n && awk;
  wire logic nos = processor_addr_strobe_n && controller_addr_strobe_n && awk;
  wire logic rdc = nos && global_write_n && byte_write_en_n
    && cycle_type inside {4'h1, 4'h2, 4'h3};
  AST_DESEL: assert property (awk && chip_sel_a_n && !controller_addr_strobe_n
    |=> res == 6'h00) else $error("deselect missed");
  AST_DESEL_SEL: assert property (awk && !chip_sel_a_n && (!chip_sel_b || chip_sel_c_n)
    && (!processor_addr_strobe_n || !controller_addr_strobe_n) |=> res == 6'h00)
    else $error("bad select not deselected");
  AST_SLEEP_IN: assert property (!sleeping && sleep_request ##1 sleep_request
    |=> sleeping) else $error("sleep entry late");
  AST_SLEEP_OUT: assert property (sleeping && !sleep_request ##1 !sleep_request
    |=> !sleeping) else $error("sleep exit late");
  AST_BEGIN_RD: assert property (sel && !processor_addr_strobe_n
    |=> res == 6'h05) else $error("begin read missed");
  AST_CTRL_WR: assert property (sel && processor_addr_strobe_n && !controller_addr_strobe_n
    && !global_write_n |=> res == 6'h11) else $error("write missed");
  AST_CONT_RD: assert property (rdc && !burst_advance_n |=> res == 6'h0B)
    else $error("continue read missed");
  AST_SUSP_RD: assert property (rdc && burst_advance_n |=> res == 6'h0E)
    else $error("suspend read missed");
  AST_SLEEP: assert property (sleep_request |=> cycle_type == 4'h7 && !data_bus_oe)
    else $error("sleep missed");
  AST_WR_MASK: assert property (cycle_type inside {4'h4, 4'h5, 4'h6} |-> !data_bus_oe)
    else $error("bus driven in write");
  AST_OE_LIVE: assert property (output_enable_n || cycle_type == 4'h0 |-> !data_bus_oe)
    else $error("bus driven while off");
endmodule
bind bscd_core bscd_checker chk_u (.*);
`default_nettype wire

// >>> verification/bscd_host.sv
// Host side model of the shared data bus
`default_nettype none
module bscd_host (
  input  wire logic        clk,
  input  wire logic        drive,
  input  wire logic [31:0] wdata,
  input  wire logic        oe,
  input  wire logic [31:0] rdata,
  output var  logic [31:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last_q;
  always @(posedge clk) last_q <= bus;
  // Released bus shows the inverse of its last value
  always_comb bus = oe ? rdata : drive ? wdata : ~last_q;
endmodule
`default_nettype wire

// >>> verification/test_burst_sram_cycle_decode.sv
// Directed bench for the burst SRAM cycle decode block
`default_nettype none
module test_burst_sram_cycle_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, sys_rst = 1'h1, lin = 1'h1, oe_n = 1'h1, slp = 1'h0, ds = 1'h0;
  logic        drv = 1'h0, oe;
  logic        cb = 1'h1, cc = 1'h0;
  logic [8:0]  m = 9'h1FF;
  logic [16:0] a = 17'h0;
  logic [31:0] d = 32'h0, bus, q, mem [0:7];
  int          err_count = 0, cmp_count = 0, j;
  bscd_core dut_u (.clk, .sys_rst, .addr(a), .processor_addr_strobe_n(m[8]),
    .controller_addr_strobe_n(m[7]), .burst_advance_n(m[6]), .chip_sel_a_n(ds),
    .chip_sel_b(cb), .chip_sel_c_n(cc), .global_write_n(m[5]), .byte_write_en_n(m[4]),
    .byte_lane_sel_n(m[3:0]), .output_enable_n(oe_n), .sleep_request(slp),
    .burst_order_linear(lin), .write_data(bus), .read_data(q), .data_bus_oe(oe),
    .cycle_type(), .addr_source(), .sleeping());
  bscd_host host_u (.clk, .drive(drv), .wdata(d), .oe, .rdata(q), .bus);
  initial forever #2 clk = ~clk;
  task automatic op(input logic [10:0] md, input logic [16:0] ad = 17'h0,
                    input logic [31:0] dt = 32'h0);
    @(negedge clk);
    {slp, ds, m} = md;
    a = ad;
    d = dt;
    drv = !(md[5] && md[4]);
    oe_n = drv;
  endtask
  task automatic chk(input logic [31:0] e);
    cmp_count++;
    if (q !== e) begin
      err_count++;
      $display("wrong value t=%0h got=%h exp=%h", $time, q, e);
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Run needs about 60 cycles
  initial begin
    #2000;
    err_count++;
    finish_test();
  end
  initial begin
    repeat (20) @(negedge clk);
    sys_rst = 1'h0;
    for (int i = 0; i < 8; i++) begin
      mem[i] = 32'hC3A5_5A30 + 32'(i);
      op(11'h15F, 17'(i), mem[i]);
    end
    op(11'h16A, 17'h1, 32'hFFFF_FFFF);
    mem[1] = mem[1] | 32'h00FF_00FF;
    op(11'h0DF, 17'h2);
    op(11'h35F, 17'h3);
    chk(mem[2]);
    cb = 1'h0;
    op(11'h0FF, 17'h3);
    cc = 1'h1;
    op(11'h55F, 17'h6);
    cb = 1'h1;
    cc = 1'h0;
    repeat (2) op(11'h55F, 17'h6);
    repeat (2) op(11'h3FF);
    for (int k = 0; k < 2; k++) begin
      lin = k[0];
      op(11'h0FF, 17'h5);
      for (int i = 0; i < 5; i++) begin
        op(i == 1 ? 11'h1FF : 11'h1BF);
        j = i - int'(i > 1);
        chk(mem[{1'h1, k ? 2'h1 + 2'(j) : 2'h1 ^ 2'(j)}]);
      end
    end
    op(11'h0FF, 17'h4);
    op(11'h1DF, 17'h0, 32'hDEAD_0004);
    op(11'h19F, 17'h0, 32'hDEAD_0005);
    op(11'h1DF, 17'h0, 32'hDEAD_0055);
    mem[4] = 32'hDEAD_0004;
    mem[5] = 32'hDEAD_0055;
    for (int i = 0; i < 9; i++) begin
      op(i < 8 ? 11'h0FF : 11'h1FF, 17'(i));
      if (i > 0) chk(mem[i - 1]);
    end
    finish_test();
  end
endmodule
`default_nettype wire
